// ---- verilog/cbc_pkg.sv ----
package cbc_pkg;
  // Register byte offsets
  localparam logic [11:0] CBC_OFF_PERIPH    = 12'h014;
  localparam logic [11:0] CBC_OFF_PINS      = 12'h018;
  localparam logic [11:0] CBC_OFF_IOBANK    = 12'h01C;
  localparam logic [11:0] CBC_OFF_BORCTL    = 12'h030;
  localparam logic [11:0] CBC_OFF_SWRST_B   = 12'h044;
  localparam logic [11:0] CBC_OFF_SWRST_C   = 12'h048;
  localparam logic [11:0] CBC_OFF_INT_STAT  = 12'h060;
  localparam logic [11:0] CBC_OFF_INT_EN    = 12'h064;
  localparam logic [11:0] CBC_OFF_INT_CLR   = 12'h068;
  // Fixed presence values
  localparam logic [31:0] CBC_PERIPH_VAL    = 32'h0107_0013;
  localparam logic [31:0] CBC_PINS_VAL      = 32'h3F3F_01FF;
  localparam logic [31:0] CBC_IOBANK_VAL    = 32'h0000_001F;
  // Brown-out control fields
  localparam int          CBC_WAIT_LSB      = 2;
  localparam int          CBC_WAIT_MSB      = 15;
  localparam int          CBC_WAIT_W        = 14;
  localparam int          CBC_SEL_BIT       = 1;
  localparam int          CBC_FILT_BIT      = 0;
  localparam logic [13:0] CBC_WAIT_RST      = 14'h1FFF;
  localparam logic        CBC_SEL_RST       = 1'b0;
  localparam logic        CBC_FILT_RST      = 1'b1;
  localparam int          CBC_MIN_COUNT     = 10000;
  // Interrupt status bit: confirmed brown-out reported as interrupt
  localparam int          CBC_IRQ_BOR       = 0;
  localparam logic [1:0]  CBC_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  CBC_RESP_SLVERR   = 2'b10;
endpackage : cbc_pkg

// ---- verilog/cbc_bor_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbc_bor_filter
  import cbc_pkg::*;
#(
  parameter int WAIT_W = CBC_WAIT_W
)(
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  // Configuration
  input  wire logic [WAIT_W-1:0] i_wait_count,
  input  wire logic              i_filter_en,
  // Detector, already synchronised
  input  wire logic              i_detect,
  // Confirmed event pulse
  output logic                   o_confirm
);
  typedef enum logic [1:0] {CBC_IDLE, CBC_WAIT, CBC_HOLD} cbc_flt_t;
  cbc_flt_t          state;
  logic [WAIT_W-1:0] count;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state     <= CBC_IDLE;
      count     <= '0;
      o_confirm <= 1'b0;
    end
    else
    begin
      o_confirm <= 1'b0;
      case (state)
        CBC_IDLE:
          if (i_detect)
          begin
            if (i_filter_en)
            begin
              state <= CBC_WAIT;
              count <= i_wait_count;
            end
            else
            begin
              o_confirm <= 1'b1;
              state     <= CBC_HOLD;
            end
          end
        CBC_WAIT:
          if (count == '0)
          begin
            // Resample point: still asserted confirms, else noise
            o_confirm <= i_detect;
            state     <= i_detect ? CBC_HOLD : CBC_IDLE;
          end
          else
            count <= count - 1'b1;
        CBC_HOLD:
          // One report per assertion; rearm once detector drops
          if (!i_detect)
            state <= CBC_IDLE;
        default:
          state <= CBC_IDLE;
      endcase
    end
  end

  a_noise_suppress: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state == CBC_WAIT && count == '0 && !i_detect) |=> !o_confirm)
    else $error("noise event reported");
  a_direct_report: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state == CBC_IDLE && i_detect && !i_filter_en) |=> o_confirm)
    else $error("unfiltered event not reported");
  a_wait_start: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state == CBC_IDLE && i_detect && i_filter_en) |=> (state == CBC_WAIT && !o_confirm))
    else $error("filter wait not started");
  a_confirm_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_confirm |-> ($past(state) != CBC_HOLD))
    else $error("confirm from hold state");
  c_filtered: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state == CBC_WAIT) ##1 o_confirm);
  c_noise: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state == CBC_WAIT && count == '0 && !i_detect));
endmodule : cbc_bor_filter
`default_nettype wire

// ---- verilog/cbc_top.sv ----
// Summary of operation
// - Peripheral presence reads comparator, timers, serial ones
// - Unused bits read zero; software leaves them
// - Pin presence bits 29:24 timer pins
// - Pin presence bits 21:16 analog inputs
// - Bits 8,7,6 comparator out, pos, neg
// - Bits 5:0 pulse outputs; 15:9 unused
// - Bank presence bits 4:0, rest unused
// - Wait count field 15:2, resets 0x1FFF
// - Wait field counts beyond ten thousand
// - Select bit picks reset or interrupt
// - Filter on: wait, resample, report if held
// - Deasserted at resample means noise, suppressed
// - Filter off: report assertion immediately
// - Software reset writes masked by presence bits
`timescale 1ns/1ps
`default_nettype none
module cbc_top
  import cbc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // AXI4-Lite write address
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [11:0] i_awaddr,
  // AXI4-Lite write data
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  // AXI4-Lite write response
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  // AXI4-Lite read address
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [11:0] i_araddr,
  // AXI4-Lite read data
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // Brown-out detector, asynchronous
  input  wire logic        i_brownout_detect,
  // Reports to system controller
  output logic             o_brownout_reset,
  output logic             o_irq,
  // Software reset outputs
  output logic [31:0]      o_swrst_periph,
  output logic [31:0]      o_swrst_bank
);
  logic                  aw_held;
  logic                  w_held;
  logic [11:0]           aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic [CBC_WAIT_W-1:0] wait_count;
  logic                  reset_select;
  logic                  filter_enable;
  logic                  int_status;
  logic                  int_enable;
  logic                  sync_meta;
  logic                  sync_detect;
  logic                  confirm;
  logic                  do_write;
  logic [31:0]           next_ctl;

  // Byte-lane merge used by the brown-out control and software reset registers
  function automatic logic [31:0] cbc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction : cbc_merge

  function automatic logic cbc_mapped(input logic [11:0] a);
    return a == CBC_OFF_PERIPH || a == CBC_OFF_PINS || a == CBC_OFF_IOBANK ||
           a == CBC_OFF_BORCTL || a == CBC_OFF_SWRST_B || a == CBC_OFF_SWRST_C ||
           a == CBC_OFF_INT_STAT || a == CBC_OFF_INT_EN || a == CBC_OFF_INT_CLR;
  endfunction : cbc_mapped

  // Write channel: address and data accepted in either order
  assign do_write = aw_held && w_held && !o_bvalid;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= '0;
      w_data    <= '0;
      w_strb    <= '0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= CBC_RESP_OKAY;
    end
    else
    begin
      o_awready <= !aw_held && !(i_awvalid && o_awready);
      o_wready  <= !w_held && !(i_wvalid && o_wready);
      if (i_awvalid && o_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= {i_awaddr[11:2], 2'b00};
      end
      if (i_wvalid && o_wready)
      begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_write)
      begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= cbc_mapped(aw_addr) ? CBC_RESP_OKAY : CBC_RESP_SLVERR;
      end
      else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end
  end

  // Read channel, one outstanding read
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= CBC_RESP_OKAY;
    end
    else
    begin
      o_arready <= !o_rvalid && !(i_arvalid && o_arready);
      if (i_arvalid && o_arready)
      begin
        o_rvalid <= 1'b1;
        o_rresp  <= cbc_mapped({i_araddr[11:2], 2'b00}) ? CBC_RESP_OKAY : CBC_RESP_SLVERR;
        // Unused bits read zero, a legal choice for indeterminate bits
        case ({i_araddr[11:2], 2'b00})
          CBC_OFF_PERIPH:   o_rdata <= CBC_PERIPH_VAL;
          CBC_OFF_PINS:     o_rdata <= CBC_PINS_VAL;
          CBC_OFF_IOBANK:   o_rdata <= CBC_IOBANK_VAL;
          CBC_OFF_BORCTL:   o_rdata <= {16'h0000, wait_count, reset_select, filter_enable};
          CBC_OFF_SWRST_B:  o_rdata <= o_swrst_periph;
          CBC_OFF_SWRST_C:  o_rdata <= o_swrst_bank;
          CBC_OFF_INT_STAT: o_rdata <= {31'h0000_0000, int_status};
          CBC_OFF_INT_EN:   o_rdata <= {31'h0000_0000, int_enable};
          default:          o_rdata <= 32'h0000_0000;
        endcase
      end
      else if (o_rvalid && i_rready)
        o_rvalid <= 1'b0;
    end
  end

  // Brown-out control register; capability offsets have no write path
  assign next_ctl = cbc_merge({16'h0000, wait_count, reset_select, filter_enable},
                              w_data, w_strb);

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_count    <= CBC_WAIT_RST;
      reset_select  <= CBC_SEL_RST;
      filter_enable <= CBC_FILT_RST;
    end
    else if (do_write && aw_addr == CBC_OFF_BORCTL)
    begin
      wait_count    <= next_ctl[CBC_WAIT_MSB:CBC_WAIT_LSB];
      reset_select  <= next_ctl[CBC_SEL_BIT];
      filter_enable <= next_ctl[CBC_FILT_BIT];
    end
  end

  // Software resets masked by presence values
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_swrst_periph <= '0;
      o_swrst_bank   <= '0;
    end
    else if (do_write)
    begin
      if (aw_addr == CBC_OFF_SWRST_B)
        o_swrst_periph <= cbc_merge(o_swrst_periph, w_data, w_strb) & CBC_PERIPH_VAL;
      if (aw_addr == CBC_OFF_SWRST_C)
        o_swrst_bank <= cbc_merge(o_swrst_bank, w_data, w_strb) & CBC_IOBANK_VAL;
    end
  end

  // Two-stage synchroniser; first stage read only by second
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync_meta   <= 1'b0;
      sync_detect <= 1'b0;
    end
    else
    begin
      sync_meta   <= i_brownout_detect;
      sync_detect <= sync_meta;
    end
  end

  cbc_bor_filter #(
    .WAIT_W (CBC_WAIT_W)
  ) cbc_bor_filter_i (
    .i_clk_sys    (i_clk_sys),
    .i_rst_n      (i_rst_n),
    .i_wait_count (wait_count),
    .i_filter_en  (filter_enable),
    .i_detect     (sync_detect),
    .o_confirm    (confirm)
  );

  // Report routing; set wins over a clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_brownout_reset <= 1'b0;
      int_status       <= 1'b0;
      int_enable       <= 1'b0;
      o_irq            <= 1'b0;
    end
    else
    begin
      o_brownout_reset <= confirm && reset_select;
      if (do_write && aw_addr == CBC_OFF_INT_EN && w_strb[0])
        int_enable <= w_data[CBC_IRQ_BOR];
      if (confirm && !reset_select)
        int_status <= 1'b1;
      else if (do_write && aw_addr == CBC_OFF_INT_CLR && w_strb[0] && w_data[CBC_IRQ_BOR])
        int_status <= 1'b0;
      o_irq <= int_status && int_enable;
    end
  end

  a_wait_width: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (2 ** CBC_WAIT_W) > CBC_MIN_COUNT)
    else $error("wait field too narrow");
  a_reset_route: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (confirm && reset_select) |=> (o_brownout_reset && !$rose(int_status)))
    else $error("reset not routed");
  a_int_route: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (confirm && !reset_select) |=> (int_status && !o_brownout_reset))
    else $error("interrupt not routed");
  a_cap_periph: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_arvalid && o_arready && i_araddr == CBC_OFF_PERIPH) |=> o_rdata == 32'h0107_0013)
    else $error("peripheral presence wrong");
  a_cap_pins: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_arvalid && o_arready && i_araddr == CBC_OFF_PINS) |=> o_rdata == 32'h3F3F_01FF)
    else $error("pin presence wrong");
  a_cap_bank: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_arvalid && o_arready && i_araddr == CBC_OFF_IOBANK) |=> o_rdata == 32'h0000_001F)
    else $error("bank presence wrong");
  a_swrst_mask: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_swrst_periph & ~CBC_PERIPH_VAL) == '0 && (o_swrst_bank & ~CBC_IOBANK_VAL) == '0)
    else $error("absent unit reset set");
  a_sync_delay: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ##2 sync_detect == $past(i_brownout_detect, 2))
    else $error("sync delay wrong");
  c_bor_reset: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $rose(o_brownout_reset));
  c_bor_irq: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $rose(o_irq));
  c_ctl_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    do_write && aw_addr == CBC_OFF_BORCTL);
endmodule : cbc_top
`default_nettype wire

// ---- test/cbc_bor_env.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbc_bor_env
(
  // Clock
  input  wire logic i_clk_sys,
  // Reset request from the block
  input  wire logic i_reset,
  // Detector level and controller tally
  output logic      o_detect,
  output var int    o_resets
);
  initial
  begin
    o_detect = 1'b0;
    o_resets = 0;
  end

  // Controller counts every reset pulse it receives
  always @(posedge i_clk_sys)
  begin
    if (i_reset === 1'b1)
      o_resets <= o_resets + 1;
  end

  // Detector held high for n clocks; released detector reads low, not stale
  task automatic assert_for(input int n);
    o_detect <= 1'b1;
    repeat (n) @(posedge i_clk_sys);
    o_detect <= 1'b0;
  endtask : assert_for
endmodule : cbc_bor_env
`default_nettype wire

// ---- test/capability_and_brownout_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module capability_and_brownout_ctrl_tb
  import cbc_pkg::*;
;
  localparam logic [31:0] P = (32'h1 << 24) | (32'h7 << 16) | (32'h1 << 4) | 32'h3;
  localparam logic [31:0] Q = (32'h3F << 24) | (32'h3F << 16) | (32'h7 << 6) | 32'h3F;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, brst, irq, det;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, sw_p, sw_b;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [33:0] notes[$];
  int          err_count, comparisons, cycles, resets, base, seed;

  always #25 clk = ~clk;

  cbc_top cbc_top_i (.i_clk_sys(clk), .i_rst_n(rst_n), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_brownout_detect(det), .o_brownout_reset(brst), .o_irq(irq),
    .o_swrst_periph(sw_p), .o_swrst_bank(sw_b));

  cbc_bor_env cbc_bor_env_i (.i_clk_sys(clk), .i_reset(brst), .o_detect(det),
    .o_resets(resets));

  task automatic finish_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk);
      ad = ad | awready;
      wd = wd | wready;
      awvalid <= awvalid & ~awready;
      wvalid  <= wvalid & ~wready;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {32'h0, bresp}, {32'h0, er});
  endtask : wr

  // Expected word noted here, compared by the read monitor
  task automatic rd(input logic [11:0] a, input logic [33:0] exp);
    @(posedge clk);
    notes.push_back(exp);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  // Settle window covers sync, the longest wait used here and the report
  task automatic bor(input int n, input int add);
    base = resets;
    @(posedge clk);
    cbc_bor_env_i.assert_for(n);
    repeat (30) @(posedge clk);
    chk("resets", 34'(resets - base), 34'(add));
  endtask : bor

  always @(posedge clk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
      chk("read", {rresp, rdata}, notes.pop_front());
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      finish_test();
    end
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    seed = 32'hA4D31204;
    {err_count, comparisons, cycles} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(CBC_OFF_PERIPH, {2'b00, P});
    rd(CBC_OFF_PINS, {2'b00, Q});
    rd(CBC_OFF_IOBANK, {2'b00, 32'h1F});
    rd(CBC_OFF_BORCTL, {18'h0, 14'h1FFF, 2'b01});
    // Only defined bits are disturbed; reserved ones are left alone
    wr(CBC_OFF_PERIPH, $random(seed) & P, 2'b00);
    wr(CBC_OFF_PINS, $random(seed) & Q, 2'b00);
    rd(CBC_OFF_PERIPH, {2'b00, P});
    rd(CBC_OFF_PINS, {2'b00, Q});
    wr(12'h100, 32'hFFFF_FFFF, 2'b10);
    rd(12'h100, {2'b10, 32'h0});
    wr(CBC_OFF_BORCTL, {16'h0, 14'h3FFF, 2'b11}, 2'b00);
    rd(CBC_OFF_BORCTL, {18'h0, 14'h3FFF, 2'b11});
    wr(CBC_OFF_SWRST_B, 32'hFFFF_FFFF, 2'b00);
    wr(CBC_OFF_SWRST_C, 32'hFFFF_FFFF, 2'b00);
    chk("swrst_periph", {2'b00, sw_p}, {2'b00, P});
    chk("swrst_bank", {2'b00, sw_b}, {2'b00, 32'h1F});
    wr(CBC_OFF_SWRST_B, 32'h0, 2'b00);
    wr(CBC_OFF_SWRST_C, 32'h0, 2'b00);
    wr(CBC_OFF_BORCTL, {16'h0, 14'h5, 2'b11}, 2'b00);
    bor(20, 1);
    bor(3, 0);
    bor(1 + ($random(seed) & 3), 0);
    wr(CBC_OFF_BORCTL, {16'h0, 14'h5, 2'b10}, 2'b00);
    bor(3, 1);
    wr(CBC_OFF_BORCTL, {16'h0, 14'h5, 2'b01}, 2'b00);
    bor(20, 0);
    rd(CBC_OFF_INT_STAT, 34'h1);
    chk("irq masked", {33'h0, irq}, 34'h0);
    wr(CBC_OFF_INT_EN, 32'h1, 2'b00);
    repeat (3) @(posedge clk);
    chk("irq enabled", {33'h0, irq}, 34'h1);
    wr(CBC_OFF_INT_CLR, 32'h1, 2'b00);
    repeat (3) @(posedge clk);
    chk("irq cleared", {33'h0, irq}, 34'h0);
    rd(CBC_OFF_INT_STAT, 34'h0);
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule : capability_and_brownout_ctrl_tb
`default_nettype wire
